/* hdl/serial_status_register_pkg.sv */
// Package for the two-wire slave receiver: register map, codes, types
package serial_status_register_pkg;

  // Register byte addresses (word aligned)
  localparam logic [3:0] SERIAL_STATUS_REGISTER_ADDR_OWN = 4'h0;
  localparam logic [3:0] SERIAL_STATUS_REGISTER_ADDR_CTRL = 4'h4;
  localparam logic [3:0] SERIAL_STATUS_REGISTER_ADDR_STAT = 4'h8;
  localparam logic [3:0] SERIAL_STATUS_REGISTER_ADDR_DATA = 4'hC;

  // Control register bit positions
  localparam int SERIAL_STATUS_REGISTER_CTL_INT = 7;
  localparam int SERIAL_STATUS_REGISTER_CTL_ACK = 6;
  localparam int SERIAL_STATUS_REGISTER_CTL_STA = 5;
  localparam int SERIAL_STATUS_REGISTER_CTL_STO = 4;
  localparam int SERIAL_STATUS_REGISTER_CTL_WC = 3;
  localparam int SERIAL_STATUS_REGISTER_CTL_EN = 2;
  localparam int SERIAL_STATUS_REGISTER_CTL_IE = 0;
  // Control bit 1 reserved, position reads zero
  localparam logic [7:0] SERIAL_STATUS_REGISTER_CTL_MASK = 8'hFD;

  // Reset values
  localparam logic [7:0] SERIAL_STATUS_REGISTER_OWN_RST = 8'h00;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_CTL_RST = 8'h00;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_IDLE_STAT = 8'hF8;

  // Status codes of slave reception
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_SLA_ACK = 8'h60;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_ARB_SLA = 8'h68;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_GC_ACK = 8'h70;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_ARB_GC = 8'h78;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_DAT_ACK = 8'h80;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_DAT_NAK = 8'h88;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_GDAT_ACK = 8'h90;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_GDAT_NAK = 8'h98;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_STOP = 8'hA0;
  localparam logic [7:0] SERIAL_STATUS_REGISTER_ST_ST_SLA = 8'hA8;
  localparam logic [6:0] SERIAL_STATUS_REGISTER_GC_ADDR = 7'h00;

  // Bit counter terminal count, eight bits per byte
  localparam logic [3:0] SERIAL_STATUS_REGISTER_BITS_ADDR = 4'h8;

  // Link state machine, one-hot
  typedef enum logic [5:0] {
    SERIAL_STATUS_REGISTER_IDLE = 6'h01,
    SERIAL_STATUS_REGISTER_ADDR = 6'h02,
    SERIAL_STATUS_REGISTER_AACK = 6'h04,
    SERIAL_STATUS_REGISTER_DATA = 6'h08,
    SERIAL_STATUS_REGISTER_DACK = 6'h10,
    SERIAL_STATUS_REGISTER_HOLD = 6'h20
  } serial_status_register_state_type;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } serial_status_register_wb_req_type;

  // Complete module state
  typedef struct packed {
    serial_status_register_state_type st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] own;
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [7:0] data;
    logic gc;
    logic addressed;
    logic nak_sent;
    logic sda_low;
    logic ack;
    logic [31:0] rdat;
    logic woke;
  } serial_status_register_regs_type;

endpackage : serial_status_register_pkg

/* hdl/serial_status_register_slave_rx.sv */
// Two-wire slave receiver with a Wishbone register port
// Notes on behaviour
// - Match seven address bits against own register
// - Own address bit zero enables general call
// - Acknowledge enable low leaves address unacknowledged
// - Write direction enters reception, read transmitter
// - Own address write acknowledged sets flag, status
// - Own address write acknowledged reports 0x60
// - After arbitration loss report 0x68 or 0x78
// - General call acknowledged reports 0x70
// - Data acknowledged under own address reports 0x80
// - Data refused under own address reports 0x88
// - Flag clear receives next byte, acks per enable
// - Clearing 0x88 returns to not-addressed slave
// - Acknowledge enable cleared: next data gets refused
// - Address recognition resumes when acknowledge reenabled
// - Deep sleep: recognise address on system clock, wake
// - After wake, hold clock low until flag cleared
// - Data register not trusted after sleep wake
`timescale 1ns/1ps
`default_nettype none

module serial_status_register_slave_rx
  import serial_status_register_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Two-wire bus pins, enables low while driving low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // System hooks
  input wire logic sleep_i,
  input wire logic arb_lost_i,
  output logic wake_o,
  output logic irq_flag_o,
  output logic transmit_mode_o
);

  serial_status_register_regs_type q, d;
  serial_status_register_wb_req_type req;
  logic scl_rise, scl_fall, start_c, stop_c, flag_set, wb_hit, wb_wr;
  logic clr_flag, ack_en, addr_hit, gc_hit;
  logic [7:0] ctl_w;

  // Bundle the bus request for decode
  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                 sel: sel_i, dat: dat_i};
  assign wb_hit = req.cyc && req.stb && !q.ack;
  assign wb_wr = wb_hit && req.we && req.sel[0];
  assign ctl_w = req.dat[7:0];

  // Edges seen only on the second synchroniser stage
  assign scl_rise = q.scl_s[1] && !q.scl_p;
  assign scl_fall = !q.scl_s[1] && q.scl_p;
  assign start_c = q.scl_s[1] && q.scl_p && q.sda_p && !q.sda_s[1];
  assign stop_c = q.scl_s[1] && q.scl_p && !q.sda_p && q.sda_s[1];

  // Writing one to the flag clears it
  assign clr_flag = wb_wr && req.adr == SERIAL_STATUS_REGISTER_ADDR_CTRL && ctl_w[SERIAL_STATUS_REGISTER_CTL_INT];
  assign ack_en = q.ctl[SERIAL_STATUS_REGISTER_CTL_ACK] && q.ctl[SERIAL_STATUS_REGISTER_CTL_EN];
  assign addr_hit = q.shift[7:1] == q.own[7:1];
  assign gc_hit = q.shift[7:1] == SERIAL_STATUS_REGISTER_GC_ADDR && q.own[0];

  // Next-state logic
  always_comb begin
    d = q;
    flag_set = 1'b0;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    d.ack = wb_hit;
    if (wb_hit && !req.we) begin
      case (req.adr)
        SERIAL_STATUS_REGISTER_ADDR_OWN: d.rdat = {24'h000000, q.own};
        SERIAL_STATUS_REGISTER_ADDR_CTRL: d.rdat = {24'h000000, q.ctl & SERIAL_STATUS_REGISTER_CTL_MASK};
        SERIAL_STATUS_REGISTER_ADDR_STAT: d.rdat = {24'h000000, q.stat};
        SERIAL_STATUS_REGISTER_ADDR_DATA: d.rdat = {24'h000000, q.data};
        default: d.rdat = 32'h00000000;
      endcase
    end
    if (wb_wr) begin
      case (req.adr)
        SERIAL_STATUS_REGISTER_ADDR_OWN: d.own = ctl_w;
        SERIAL_STATUS_REGISTER_ADDR_CTRL: begin
          d.ctl[6:0] = ctl_w[6:0] & SERIAL_STATUS_REGISTER_CTL_MASK[6:0];
          d.ctl[SERIAL_STATUS_REGISTER_CTL_WC] = q.ctl[SERIAL_STATUS_REGISTER_CTL_WC];
        end
        SERIAL_STATUS_REGISTER_ADDR_DATA: begin
          // Write while busy on the bus is a collision
          if (!q.ctl[SERIAL_STATUS_REGISTER_CTL_INT])
            d.ctl[SERIAL_STATUS_REGISTER_CTL_WC] = 1'b1;
          else
            d.data = ctl_w;
        end
        default: ;
      endcase
    end
    if (clr_flag) begin
      d.ctl[SERIAL_STATUS_REGISTER_CTL_INT] = 1'b0;
      d.ctl[SERIAL_STATUS_REGISTER_CTL_WC] = 1'b0;
    end
    // Link state machine
    case (q.st)
      SERIAL_STATUS_REGISTER_IDLE: begin
        d.sda_low = 1'b0;
        if (start_c && q.ctl[SERIAL_STATUS_REGISTER_CTL_EN]) begin
          d.st = SERIAL_STATUS_REGISTER_ADDR;
          d.bitn = 4'h0;
        end
      end
      SERIAL_STATUS_REGISTER_ADDR, SERIAL_STATUS_REGISTER_DATA: begin
        if (scl_rise) begin
          d.shift = {q.shift[6:0], q.sda_s[1]};
          d.bitn = q.bitn + 4'h1;
        end
        if (scl_fall && q.bitn == SERIAL_STATUS_REGISTER_BITS_ADDR) begin
          d.bitn = 4'h0;
          if (q.st == SERIAL_STATUS_REGISTER_ADDR) begin
            if (ack_en && (addr_hit || gc_hit)) begin
              d.st = SERIAL_STATUS_REGISTER_AACK;
              d.sda_low = 1'b1;
              d.gc = !addr_hit;
            end else begin
              d.st = SERIAL_STATUS_REGISTER_IDLE;
            end
          end else begin
            d.st = SERIAL_STATUS_REGISTER_DACK;
            d.data = q.shift;
            d.sda_low = q.addressed && ack_en;
            d.nak_sent = !(q.addressed && ack_en);
          end
        end
      end
      SERIAL_STATUS_REGISTER_AACK, SERIAL_STATUS_REGISTER_DACK: begin
        if (scl_fall) begin
          d.sda_low = 1'b0;
          d.st = SERIAL_STATUS_REGISTER_HOLD;
          flag_set = 1'b1;
          if (q.st == SERIAL_STATUS_REGISTER_AACK) begin
            d.addressed = !q.shift[0];
            if (q.shift[0])
              d.stat = SERIAL_STATUS_REGISTER_ST_ST_SLA;
            else if (arb_lost_i)
              d.stat = q.gc ? SERIAL_STATUS_REGISTER_ST_ARB_GC : SERIAL_STATUS_REGISTER_ST_ARB_SLA;
            else if (q.gc)
              d.stat = SERIAL_STATUS_REGISTER_ST_GC_ACK;
            else
              d.stat = SERIAL_STATUS_REGISTER_ST_SLA_ACK;
          end else if (q.nak_sent) begin
            d.stat = q.gc ? SERIAL_STATUS_REGISTER_ST_GDAT_NAK : SERIAL_STATUS_REGISTER_ST_DAT_NAK;
          end else begin
            d.stat = q.gc ? SERIAL_STATUS_REGISTER_ST_GDAT_ACK : SERIAL_STATUS_REGISTER_ST_DAT_ACK;
          end
        end
      end
      SERIAL_STATUS_REGISTER_HOLD: begin
        if (!q.ctl[SERIAL_STATUS_REGISTER_CTL_INT] && !flag_set) begin
          d.woke = 1'b0;
          // refused byte ends the addressed phase
          if (q.nak_sent || !q.addressed) begin
            d.st = SERIAL_STATUS_REGISTER_IDLE;
            d.addressed = 1'b0;
            d.nak_sent = 1'b0;
            d.stat = SERIAL_STATUS_REGISTER_IDLE_STAT;
          end else begin
            d.st = SERIAL_STATUS_REGISTER_DATA;
            d.bitn = 4'h0;
          end
        end
      end
      default: d.st = SERIAL_STATUS_REGISTER_IDLE;
    endcase
    // Stop or repeated start while addressed
    // A stop or start follows the first clock rise of a byte, which
    // has already stepped the bit counter to one
    if ((stop_c || start_c) && q.addressed && q.st == SERIAL_STATUS_REGISTER_DATA
        && q.bitn == 4'h1) begin
      d.st = start_c ? SERIAL_STATUS_REGISTER_ADDR : SERIAL_STATUS_REGISTER_IDLE;
      d.bitn = 4'h0;
      d.stat = SERIAL_STATUS_REGISTER_ST_STOP;
      d.addressed = 1'b0;
      flag_set = 1'b1;
    end
    // in sleep any flag set raises a wake request
    if (flag_set && sleep_i)
      d.woke = 1'b1;
    // Set wins over a same-cycle software clear
    if (flag_set)
      d.ctl[SERIAL_STATUS_REGISTER_CTL_INT] = 1'b1;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= SERIAL_STATUS_REGISTER_IDLE;
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.own <= SERIAL_STATUS_REGISTER_OWN_RST;
      q.ctl <= SERIAL_STATUS_REGISTER_CTL_RST;
      q.stat <= SERIAL_STATUS_REGISTER_IDLE_STAT;
    end else begin
      q <= d;
    end
  end

  // Pin drive; open drain, only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  // hold also covers wake from sleep
  assign scl_oe_n_o = !(q.st == SERIAL_STATUS_REGISTER_HOLD && q.ctl[SERIAL_STATUS_REGISTER_CTL_INT]);
  assign sda_oe_n_o = !q.sda_low;
  // data register left unchanged on wake
  assign wake_o = q.woke;
  assign irq_flag_o = q.ctl[SERIAL_STATUS_REGISTER_CTL_INT] && q.ctl[SERIAL_STATUS_REGISTER_CTL_IE];
  assign transmit_mode_o = q.stat == SERIAL_STATUS_REGISTER_ST_ST_SLA;
  assign dat_o = q.rdat;
  assign ack_o = q.ack;

  // Assertions
  sequence s_addr_acked;
    q.st == SERIAL_STATUS_REGISTER_AACK && scl_fall && !q.shift[0];
  endsequence

  a_status_sla: assert property (@(posedge clk_i) disable iff (rst_i)
    s_addr_acked and (!q.gc && !arb_lost_i) |=> q.stat == SERIAL_STATUS_REGISTER_ST_SLA_ACK)
    else $error("own address status wrong");
  a_flag_after_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_addr_acked |=> q.ctl[SERIAL_STATUS_REGISTER_CTL_INT] && q.st == SERIAL_STATUS_REGISTER_HOLD)
    else $error("flag not set after address");
  a_gc_status: assert property (@(posedge clk_i) disable iff (rst_i)
    s_addr_acked and (q.gc && !arb_lost_i) |=> q.stat == SERIAL_STATUS_REGISTER_ST_GC_ACK)
    else $error("general call status wrong");
  a_arb_status: assert property (@(posedge clk_i) disable iff (rst_i)
    s_addr_acked and arb_lost_i |=>
      q.stat == SERIAL_STATUS_REGISTER_ST_ARB_GC || q.stat == SERIAL_STATUS_REGISTER_ST_ARB_SLA)
    else $error("arbitration status wrong");
  a_no_ack_off: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == SERIAL_STATUS_REGISTER_ADDR && !ack_en |=> q.st != SERIAL_STATUS_REGISTER_AACK)
    else $error("address acked while disabled");
  a_gc_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.st == SERIAL_STATUS_REGISTER_AACK) && q.gc |-> q.own[0])
    else $error("general call without enable");
  a_stretch_held: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == SERIAL_STATUS_REGISTER_HOLD && q.ctl[SERIAL_STATUS_REGISTER_CTL_INT] |-> !scl_oe_n_o)
    else $error("clock not stretched");
  a_data_nak: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == SERIAL_STATUS_REGISTER_DACK && scl_fall && q.nak_sent && !q.gc
      |=> q.stat == SERIAL_STATUS_REGISTER_ST_DAT_NAK ##1 q.ctl[SERIAL_STATUS_REGISTER_CTL_INT])
    else $error("refused data status wrong");
  a_nak_release: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == SERIAL_STATUS_REGISTER_HOLD && !q.ctl[SERIAL_STATUS_REGISTER_CTL_INT] && q.nak_sent
      |=> q.st == SERIAL_STATUS_REGISTER_IDLE && !q.addressed)
    else $error("not released after refused byte");

endmodule // serial_status_register_slave_rx

`default_nettype wire

/* tb/serial_status_register_bus_master.sv */
// Behavioural two-wire bus master transmitter driving the slave
`timescale 1ns/1ps
`default_nettype none

module serial_status_register_bus_master (
  // Open-drain drives, high releases the line
  output logic scl_m_o,
  output logic sda_m_o,
  // Resolved line levels
  input wire logic scl_i,
  input wire logic sda_i
);
  localparam int HALF = 32;

  // Lines released while no frame runs
  initial begin
    scl_m_o = 1'b1;
    sda_m_o = 1'b1;
  end

  // Release clock, then wait out any stretch held by the slave
  task automatic rel_scl();
    int n;
    n = 0;
    scl_m_o = 1'b1;
    while (scl_i !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask

  // One pulse; data changes well after the fall to avoid false events
  task automatic pulse(input logic v, output logic s);
    sda_m_o = v;
    #(HALF - 8);
    rel_scl();
    #HALF;
    s = sda_i; // Late in high phase, slave still drives
    scl_m_o = 1'b0;
    #8;
  endtask

  // Start: data falls while clock high
  task automatic start_c();
    sda_m_o = 1'b0;
    #HALF;
    scl_m_o = 1'b0;
    #8;
  endtask

  // Stop: data rises while clock high
  task automatic stop_c();
    sda_m_o = 1'b0;
    #(HALF - 8);
    rel_scl();
    #HALF;
    sda_m_o = 1'b1;
    #HALF;
  endtask

  // Byte MSB first, then ninth pulse with data released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, ack);
  endtask
endmodule // serial_status_register_bus_master

`default_nettype wire

/* tb/serial_status_register_slave_rx_tb.sv */
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s exp %h got %h", nm, e, g); end end

module serial_status_register_slave_rx_tb
  import serial_status_register_pkg::*;
;
  localparam logic [7:0] F_B = 8'h01 << SERIAL_STATUS_REGISTER_CTL_INT;
  localparam logic [7:0] RUN = 8'h45; // Ack, enable, irq enable
  localparam logic [7:0] NAK = 8'h05; // Enable and irq enable only
  typedef struct { logic [7:0] e; logic [7:0] m; } serial_status_register_exp_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sleep_i = 1'b0;
  logic arb_i = 1'b0;
  serial_status_register_wb_req_type req = '0;
  logic [31:0] dat_o;
  logic ack_o, scl_o, scl_oe_n, sda_o, sda_oe_n, wake_o, irq_o, tx_o;
  wire scl_w, sda_w, scl_m, sda_m;
  int err_total = 0;
  int n_compared = 0;
  serial_status_register_exp_type exq[$];
  logic a;
  logic [6:0] own7;
  logic [7:0] d;

  // Clock and wired-AND lines with pull-ups
  always #4 clk_i = ~clk_i;
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  serial_status_register_slave_rx u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc),
    .stb_i(req.stb), .we_i(req.we), .adr_i(req.adr), .sel_i(req.sel),
    .dat_i(req.dat), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .sleep_i(sleep_i), .arb_lost_i(arb_i),
    .wake_o(wake_o), .irq_flag_o(irq_o), .transmit_mode_o(tx_o));
  serial_status_register_bus_master u_mst (.scl_m_o(scl_m), .sda_m_o(sda_m), .scl_i(scl_w),
    .sda_i(sda_w));

  // Read answers matched against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && req.we === 1'b0 && exq.size() > 0) begin
      `CHK("read", exq[0].e & exq[0].m, dat_o[7:0] & exq[0].m)
      void'(exq.pop_front());
    end
  end

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, ad, 4'h1, {24'h0, v}};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    req <= '0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [7:0] e,
                    input logic [7:0] m);
    exq.push_back('{e, m});
    wb(1'b0, ad, 8'h00);
  endtask

  // Wait for the flag, then the status code
  task automatic got(input logic [7:0] e);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("flag", 1'b1, irq_o)
    rd(SERIAL_STATUS_REGISTER_ADDR_STAT, e, 8'hF8);
  endtask

  task automatic addr(input logic [7:0] b, input logic e);
    u_mst.start_c();
    u_mst.send_byte(b, a);
    `CHK("ack", e, a)
  endtask

  // Clear flag, stop while addressed, clear again
  task automatic fin();
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, F_B | RUN);
    u_mst.stop_c();
    got(SERIAL_STATUS_REGISTER_ST_STOP);
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, F_B | RUN);
  endtask

  // Held clock must stay low until software clears the flag
  task automatic held_byte();
    d = 8'($urandom);
    fork
      u_mst.send_byte(d, a);
      begin
        repeat (20) @(posedge clk_i);
        `CHK("scl", 1'b0, scl_w)
        sleep_i <= 1'b0;
        wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, F_B | RUN);
      end
    join
    `CHK("ack", 1'b0, a)
  endtask

  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hae7c));
    own7 = 7'(1 + $urandom % 126);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SERIAL_STATUS_REGISTER_ADDR_OWN, SERIAL_STATUS_REGISTER_OWN_RST, 8'hFF);
    rd(SERIAL_STATUS_REGISTER_ADDR_CTRL, SERIAL_STATUS_REGISTER_CTL_RST, 8'hFF);
    rd(SERIAL_STATUS_REGISTER_ADDR_STAT, SERIAL_STATUS_REGISTER_IDLE_STAT, 8'hF8);
    rd(4'h2, 8'h00, 8'hFF);
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_OWN, {own7, 1'b1});
    rd(SERIAL_STATUS_REGISTER_ADDR_OWN, {own7, 1'b1}, 8'hFF);
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, RUN);
    addr({own7, 1'b0}, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_SLA_ACK);
    held_byte();
    got(SERIAL_STATUS_REGISTER_ST_DAT_ACK);
    rd(SERIAL_STATUS_REGISTER_ADDR_DATA, d, 8'hFF);
    // Acknowledge withdrawn: next byte refused, then unaddressed
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, F_B | NAK);
    d = 8'($urandom);
    u_mst.send_byte(d, a);
    `CHK("nak", 1'b1, a)
    got(SERIAL_STATUS_REGISTER_ST_DAT_NAK);
    rd(SERIAL_STATUS_REGISTER_ADDR_DATA, d, 8'hFF);
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, F_B | RUN);
    u_mst.stop_c();
    rd(SERIAL_STATUS_REGISTER_ADDR_STAT, SERIAL_STATUS_REGISTER_IDLE_STAT, 8'hF8);
    addr({own7 + 7'h1, 1'b0}, 1'b1);
    u_mst.stop_c();
    addr(8'h00, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_GC_ACK);
    fin();
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_OWN, {own7, 1'b0});
    addr(8'h00, 1'b1);
    u_mst.stop_c();
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, NAK);
    addr({own7, 1'b0}, 1'b1);
    u_mst.stop_c();
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, RUN);
    addr({own7, 1'b0}, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_SLA_ACK);
    fin();
    // Lost arbitration as master, then addressed
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_OWN, {own7, 1'b1});
    arb_i <= 1'b1;
    addr({own7, 1'b0}, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_ARB_SLA);
    fin();
    addr(8'h00, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_ARB_GC);
    fin();
    arb_i <= 1'b0;
    addr({own7, 1'b1}, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_ST_SLA);
    `CHK("txmode", 1'b1, tx_o)
    // Second reset clears the unfinished read transfer
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    u_mst.rel_scl();
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_OWN, {own7, 1'b1});
    wb(1'b1, SERIAL_STATUS_REGISTER_ADDR_CTRL, RUN);
    // Deep sleep; data register left unchecked after wake
    sleep_i <= 1'b1;
    addr({own7, 1'b0}, 1'b0);
    got(SERIAL_STATUS_REGISTER_ST_SLA_ACK);
    `CHK("wake", 1'b1, wake_o)
    held_byte();
    got(SERIAL_STATUS_REGISTER_ST_DAT_ACK);
    `CHK("wake", 1'b0, wake_o)
    final_report();
  end
endmodule // serial_status_register_slave_rx_tb

`default_nettype wire
